// ### common/lpm_pkg.sv
// Purpose: constants and carrier types for the led select / power mode block
// Assumes: 8-bit host register port, one 200 MHz clock
// Notes: bit positions follow the power and led configuration register layout
package lpm_pkg;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int BIT_LED12_SEL = 5;
    localparam int BIT_LED0_SEL = 4;
    localparam int BIT_RESERVED = 3;
    localparam int BIT_SLEEP = 2;
    localparam int BIT_POWER_DOWN = 1;
    localparam int BIT_INACTIVE = 0;
    localparam logic [7:0] HALT_CODE_RUN = 8'h52;
    localparam logic [7:0] HALT_CODE_HALT = 8'h48;
    localparam logic [1:0] EEPROM_MODE_CFG = 2'h3;

    typedef enum logic [1:0] {LPM_MODE_OFF, LPM_MODE_RUN, LPM_MODE_HALT} lpm_mode_t;

    // network status inputs feeding the led selection
    typedef struct packed {
        logic collision;
        logic link;
        logic receive;
        logic transmit;
        logic carrier_sense;
        logic coax;
    } lpm_status_t;

    // led pin drive, active low leds
    typedef struct packed {
        logic led0;
        logic led1;
        logic led2;
        logic coax_indicator_led;
    } lpm_leds_t;
endpackage

// ### rtl/lpm_power_led_ctrl.sv
// Purpose: power and led configuration register, sleep / power-down, led mux
// Assumes: host register strobes are synchronous to clk; status inputs are
//          asynchronous and synchronised here
// Notes: the clock halt itself is signalled out; the clock gate sits elsewhere
//        and must keep the halt register path alive while stopped
//        the led pins are active low: a forced high level means dark

module lpm_power_led_ctrl (
    input wire logic clk, // 200 mhz system clock
    input wire logic rst, // asynchronous reset, active high
    input wire logic cfg_write, // one-cycle write strobe to configuration reg
    input wire logic [7:0] cfg_wdata, // data for configuration write
    output logic [7:0] cfg_rdata, // configuration register read value
    input wire logic halt_write, // one-cycle write strobe to halt register
    input wire logic [7:0] halt_wdata, // data for halt register write
    input wire logic group1_req, // host access to group one register
    input wire logic group1_is_halt, // that access targets the halt register
    input wire logic boot_rom_req, // host boot rom memory read
    output logic group1_grant, // access may proceed
    output logic boot_rom_grant, // boot rom read may proceed
    input wire logic pnp_activate, // pnp activate register bit 0
    input wire logic eeprom_mode_select_high, // eeprom mode bit 1
    input wire logic eeprom_mode_select_low, // eeprom mode bit 0
    input wire logic power_down_init, // power-down start value at load
    input wire logic power_down_init_load, // one-cycle load of power-down
    input wire logic dma_active, // local dma in progress
    input wire lpm_pkg::lpm_status_t status_in, // raw network status pins
    output lpm_pkg::lpm_leds_t leds, // led pin drive
    output logic sram_standby_select, // sram chip select, low selects
    output logic network_enable, // serial interface and transceiver on
    output logic clock_halt_req, // request internal clock stop
    output lpm_pkg::lpm_mode_t power_mode // current power-down mode
);
    // host visible configuration state
    logic [1:0] led_sel;
    logic [1:0] next_led_sel;
    logic sleep;
    logic next_sleep;
    logic power_down;
    logic next_power_down;
    lpm_pkg::lpm_mode_t mode;
    lpm_pkg::lpm_mode_t next_mode;
    // status pin synchroniser stages
    lpm_pkg::lpm_status_t sync1;
    lpm_pkg::lpm_status_t sync2;
    lpm_pkg::lpm_status_t next_sync1;
    lpm_pkg::lpm_status_t next_sync2;
    // led and sram select drive
    lpm_pkg::lpm_leds_t next_leds;
    logic next_standby;
    // decoded conditions
    logic eeprom_cfg;
    logic inactive_flag;
    logic halted;

    // both eeprom mode bits high is the only state that unlocks the power bits
    assign eeprom_cfg = {eeprom_mode_select_high, eeprom_mode_select_low}
        == lpm_pkg::EEPROM_MODE_CFG;
    // activation is owned by the pnp logic; this block only mirrors it
    assign inactive_flag = ~pnp_activate;
    assign halted = (mode == lpm_pkg::LPM_MODE_HALT);

    // register updates; reserved bit is simply not stored
    always_comb
    begin
        next_led_sel = led_sel;
        next_sleep = sleep;
        next_power_down = power_down;
        next_mode = mode;
        // eeprom load of the power-down start value
        if (power_down_init_load)
        begin
            next_power_down = power_down_init;
        end
        // config register sits in group one, so it is gated like the rest
        if (cfg_write && !inactive_flag && !halted)
        begin
            // led selects are taken even while the power bits are locked
            next_led_sel = {cfg_wdata[lpm_pkg::BIT_LED12_SEL],
                cfg_wdata[lpm_pkg::BIT_LED0_SEL]};
            // a locked write leaves sleep and power-down untouched
            if (eeprom_cfg)
            begin
                next_sleep = cfg_wdata[lpm_pkg::BIT_SLEEP];
                next_power_down = cfg_wdata[lpm_pkg::BIT_POWER_DOWN];
            end
        end
        // halt register stays live when inactive so a halted part can wake
        if (halt_write && power_down)
        begin
            unique case (halt_wdata)
                lpm_pkg::HALT_CODE_RUN:
                begin
                    next_mode = lpm_pkg::LPM_MODE_RUN;
                end
                lpm_pkg::HALT_CODE_HALT:
                begin
                    next_mode = lpm_pkg::LPM_MODE_HALT;
                end
                default:
                begin
                    next_mode = mode; // any other code is ignored
                end
            endcase
        end
        // leaving power-down drops back to normal; a fresh power-down starts
        // with the clock running, the only mode that cannot strand the part
        if (!next_power_down)
        begin
            next_mode = lpm_pkg::LPM_MODE_OFF;
        end
        else if (mode == lpm_pkg::LPM_MODE_OFF && next_mode == lpm_pkg::LPM_MODE_OFF)
        begin
            next_mode = lpm_pkg::LPM_MODE_RUN;
        end
    end

    // register state; nothing but the clock and reset moves these
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            led_sel <= 2'h0;
            sleep <= 1'b0;
            power_down <= 1'b0;
            mode <= lpm_pkg::LPM_MODE_OFF;
        end
        else
        begin
            led_sel <= next_led_sel;
            sleep <= next_sleep;
            power_down <= next_power_down;
            mode <= next_mode;
        end
    end

    // two-stage synchroniser for pin status; the pins run free of clk, so
    // only the second stage may feed the led mux
    always_comb
    begin
        next_sync1 = status_in;
        next_sync2 = sync1;
    end

    // synchroniser stages
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1 <= '0;
            sync2 <= '0;
        end
        else
        begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
        end
    end

    // led mux; leds are active low so forcing high turns them off
    always_comb
    begin
        next_standby = ~dma_active;
        next_leds.led0 = led_sel[0] ? ~sync2.link : ~sync2.collision;
        next_leds.led1 = led_sel[1] ? ~sync2.carrier_sense : ~sync2.receive;
        next_leds.led2 = led_sel[1] ? next_standby : ~sync2.transmit;
        next_leds.coax_indicator_led = ~sync2.coax;
        if (sleep || power_down)
        begin
            next_leds.led0 = 1'b1;
            next_leds.led1 = 1'b1;
            next_leds.led2 = 1'b1;
        end
        if (power_down)
        begin
            next_leds.coax_indicator_led = 1'b0;
        end
    end

    // led pins come from flops so they never glitch while the mux settles
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            leds <= '1;
            sram_standby_select <= 1'b1;
        end
        else
        begin
            leds <= next_leds;
            sram_standby_select <= next_standby;
        end
    end

    // sleep leaves the network alone; only power-down turns it off
    assign network_enable = ~power_down;
    assign clock_halt_req = halted;
    assign power_mode = mode;
    // the halt register stays reachable in every state so a halted part can wake
    assign group1_grant = group1_req
        && (group1_is_halt || (!inactive_flag && !halted));
    assign boot_rom_grant = boot_rom_req && !inactive_flag && !halted;
    // reserved bit reads zero; activation itself lives in pnp logic
    assign cfg_rdata = {2'h0, led_sel[1], led_sel[0], 1'b0, sleep, power_down,
        inactive_flag};
endmodule

// ### verif/lpm_host_model.sv
// Purpose: host driver issuing register write strobes
// Assumes: strobes change at the falling edge, one cycle each
// Notes: the reserved bit is always written as zero
module lpm_host_model (
    input wire logic clk, // clock
    output logic cfg_write, // cfg strobe
    output logic [7:0] cfg_wdata, // cfg data
    output logic halt_write, // halt strobe
    output logic [7:0] halt_wdata // halt data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {cfg_write, halt_write, cfg_wdata, halt_wdata} = 18'h0;
    // h picks the halt register; strobe spans exactly one rising edge
    task automatic wr(input logic h, input logic [7:0] d);
        @(negedge clk);
        cfg_write = !h;
        halt_write = h;
        cfg_wdata = d & 8'hf7;
        halt_wdata = d;
        @(negedge clk);
        {cfg_write, halt_write} = 2'h0;
    endtask
endmodule

// ### verif/lpm_power_led_ctrl_monitor.sv
// Purpose: port checker for the power and led control block
// Assumes: one clock, rst async active high
// Notes: watches design inputs and outputs
module lpm_power_led_ctrl_monitor (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic cfg_write, // cfg strobe
    input wire logic halt_write, // halt strobe
    input wire logic [7:0] halt_wdata, // halt data
    input wire logic [7:0] cfg_rdata, // cfg readback
    input wire logic pnp_activate, // activate bit
    input wire logic dma_active, // dma busy
    input wire logic power_down_init_load, // eeprom load of power-down
    input wire lpm_pkg::lpm_leds_t leds, // led pins
    input wire logic sram_standby_select, // sram select
    input wire logic network_enable, // network on
    input wire logic clock_halt_req, // clock stop
    input wire lpm_pkg::lpm_mode_t power_mode // mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // two-cycle antecedents let registered fields settle before leds are judged
    net_off_a: assert property (network_enable == !cfg_rdata[1])
        else $error("network enable wrong");
    halt_req_a: assert property (clock_halt_req == (power_mode == lpm_pkg::LPM_MODE_HALT))
        else $error("halt request wrong");
    inact_a: assert property ($stable(pnp_activate) |-> cfg_rdata[0] != pnp_activate)
        else $error("inactive flag wrong");
    standby_a: assert property (!$past(rst) |-> sram_standby_select == !$past(dma_active))
        else $error("sram standby wrong");
    sleep_led_a: assert property (cfg_rdata[2] [*2] |-> leds[3:1] == 3'h7)
        else $error("sleep leds lit");
    pd_coax_a: assert property (cfg_rdata[1] [*2] |-> !leds.coax_indicator_led)
        else $error("coax led not low");
    halt_ign_a: assert property
        (halt_write && !(cfg_write || power_down_init_load || cfg_rdata[1])
        |=> $stable(power_mode))
        else $error("halt write not ignored");
    halt_code_a: assert property
        (halt_write && !cfg_write && !power_down_init_load && cfg_rdata[1]
        && halt_wdata == lpm_pkg::HALT_CODE_HALT
        |=> power_mode == lpm_pkg::LPM_MODE_HALT) else $error("halt code not taken");
endmodule
bind lpm_power_led_ctrl lpm_power_led_ctrl_monitor u_mon (.clk, .rst, .cfg_write, .halt_write,
    .halt_wdata, .cfg_rdata, .pnp_activate, .dma_active, .leds, .sram_standby_select,
    .network_enable, .clock_halt_req, .power_mode, .power_down_init_load);

// ### verif/lpm_power_led_ctrl_tb.sv
// Purpose: self-checking bench for the power and led control block
// Assumes: inputs change at the falling edge; leds active low
// Notes: four cycles cover the status synchroniser and led register
module lpm_power_led_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, cw, hw, g1, g1h, rom_rq, act, eh, el, dma, g1g, bg, ne, chr, sb, pdi, pdl;
    logic [7:0] wd, hd, rd;
    lpm_pkg::lpm_status_t st;
    lpm_pkg::lpm_leds_t leds;
    lpm_pkg::lpm_mode_t pm;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    // rows: config, status, dma, leds; halt rows: code, grant, halt req, mode
    logic [23:0] rows [4] = '{24'h002405, 24'h101207, 24'h200318, 24'h303007};
    logic [11:0] hc [3] = '{12'h119, 12'h486, 12'h529};
    lpm_host_model u_host (.clk(clk), .cfg_write(cw), .cfg_wdata(wd), .halt_write(hw),
        .halt_wdata(hd));
    lpm_power_led_ctrl u_dut (.clk(clk), .rst(rst), .cfg_write(cw), .cfg_wdata(wd),
        .cfg_rdata(rd), .halt_write(hw), .halt_wdata(hd), .group1_req(g1),
        .group1_is_halt(g1h), .boot_rom_req(rom_rq), .group1_grant(g1g), .boot_rom_grant(bg),
        .pnp_activate(act), .eeprom_mode_select_high(eh), .eeprom_mode_select_low(el),
        .power_down_init(pdi), .power_down_init_load(pdl), .dma_active(dma),
        .status_in(st), .leds(leds), .sram_standby_select(sb), .network_enable(ne),
        .clock_halt_req(chr), .power_mode(pm));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e)
        begin
            err_count++;
            $display("unexpected %s exp %h saw %h", n, e, s);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = !clk;
    end
    // hang guard, well above the 57 or so cycles the tests need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 2000)
        begin
            err_count++;
            report_and_stop();
        end
    end
    initial
    begin
        {rst, g1, g1h, rom_rq, act, eh, el, dma, st, pdi, pdl} = {8'hde, 8'h00};
        repeat (3) @(negedge clk);
        chk("reset", rd, 8'h00);
        rst = 1'b0;
        foreach (rows[i])
        begin
            u_host.wr(1'b0, rows[i][23:16]);
            st = rows[i][13:8];
            dma = rows[i][4];
            repeat (4) @(negedge clk);
            chk("leds", {4'h0, leds}, {4'h0, rows[i][3:0]});
            chk("cfg", rd, rows[i][23:16]);
            chk("standby", {7'h0, sb}, {7'h0, !rows[i][4]});
        end
        $display("led table done");
        st = 6'h01;
        u_host.wr(1'b0, 8'h04);
        @(negedge clk);
        chk("sleep", {3'h0, ne, leds}, 8'h1e);
        eh = 1'b0;
        u_host.wr(1'b0, 8'h00);
        chk("sleep lock", rd, 8'h04);
        eh = 1'b1;
        u_host.wr(1'b0, 8'h02);
        @(negedge clk);
        chk("pdown", {ne, chr, pm, leds}, 8'h1e);
        foreach (hc[i])
        begin
            u_host.wr(1'b1, hc[i][11:4]);
            chk("mode", {4'h0, g1g, chr, pm}, {4'h0, hc[i][3:0]});
        end
        u_host.wr(1'b0, 8'h00);
        u_host.wr(1'b1, 8'h48);
        chk("no pdown", {5'h0, chr, pm}, 8'h00);
        $display("power modes done");
        act = 1'b0;
        repeat (2) @(negedge clk);
        chk("inactive", {5'h0, rd[0], g1g, bg}, 8'h04);
        g1h = 1'b1;
        @(negedge clk);
        chk("halt grant", {7'h0, g1g}, 8'h01);
        act = 1'b1;
        g1h = 1'b0;
        repeat (2) @(negedge clk);
        chk("active", {6'h0, g1g, bg}, 8'h03);
        $display("access gating done");
        g1 = 1'b0;
        rom_rq = 1'b0;
        @(negedge clk);
        chk("no request", {6'h0, g1g, bg}, 8'h00);
        u_host.wr(1'b0, 8'h36);
        chk("pre reset", rd, 8'h36);
        rst = 1'b1;
        @(negedge clk);
        chk("mid reset", rd, 8'h00);
        chk("reset outs", {ne, chr, pm, leds}, 8'h8f);
        chk("reset standby", {7'h0, sb}, 8'h01);
        rst = 1'b0;
        eh = 1'b0;
        u_host.wr(1'b0, 8'h34);
        chk("locked after reset", rd, 8'h30);
        {pdi, pdl} = 2'h3;
        @(negedge clk);
        pdl = 1'b0;
        chk("pd load", {ne, chr, pm, 2'h0, rd[1:0]}, 8'h12);
        $display("mid-run reset done");
        report_and_stop();
    end
endmodule
